// [src/clk_rst_pkg.sv]
package clk_rst_pkg;

	// Management clock rate and derived timing
	localparam int unsigned SYS_CLK_PERIOD_NS = 10;
	localparam int unsigned HOLD_CYCLES       = 10;
	localparam int unsigned ACT_WINDOW_NS     = 160;
	localparam int unsigned ACT_WINDOW_CYCLES = (ACT_WINDOW_NS + SYS_CLK_PERIOD_NS - 1)
		/ SYS_CLK_PERIOD_NS;

	// Register byte offsets
	localparam logic [7:0] CTRL_OFFSET   = 8'h00;
	localparam logic [7:0] STATUS_OFFSET = 8'h04;
	localparam logic [7:0] INFO_OFFSET   = 8'h08;

	// Control field positions
	localparam int unsigned CTRL_EXT_TX_BIT = 0;
	localparam int unsigned CTRL_SYNCE_BIT  = 1;
	localparam int unsigned CTRL_SOFT_BIT   = 2;

	// Status field positions
	localparam int unsigned STAT_ACT_LSB    = 0;
	localparam int unsigned STAT_LOCK_BIT   = 3;
	localparam int unsigned STAT_RDY_BIT    = 4;
	localparam int unsigned STAT_FSM_LSB    = 8;

	// Reset values
	localparam logic [2:0] CTRL_RESET = 3'h0;

	// AXI responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Register selector codes
	localparam logic [1:0] SEL_CTRL   = 2'h0;
	localparam logic [1:0] SEL_STATUS = 2'h1;
	localparam logic [1:0] SEL_INFO   = 2'h2;
	localparam logic [1:0] SEL_NONE   = 2'h3;

	// Reset sequencer states
	typedef enum logic [4:0] {
		ST_HOLD     = 5'b00001,
		ST_WAIT_REF = 5'b00010,
		ST_PLL      = 5'b00100,
		ST_TX       = 5'b01000,
		ST_RUN      = 5'b10000
	} seq_state_t;

endpackage

// [src/clk_rst_ctrl.sv]
// Notes on behaviour
// - Transceiver and coding clocks come from reference clock through internal PLL.
// - Transmit MAC runs on 312.5 MHz core clock, also presented as output.
// - External transmit PLL option makes that input the transmit core clock.
// - Receive core clock of 312.5 MHz derives from recovered clock, needs data.
// - Recovered clock output at 257.8125 MHz only with synchronous-Ethernet option, unfiltered.
// - The single asynchronous reset input resets the whole core.
// - Management interface has its own synchronous reset on management clock.
`timescale 1ns/1ps
`default_nettype none

module clk_rst_ctrl
(
	// Management clock and reset
	input  wire logic        sys_clk_in,
	input  wire logic        rst_n_in,
	input  wire logic        mgmt_reset_in,
	// Core reset and clock observation pins
	input  wire logic        core_reset_in,
	input  wire logic        ref_clk_in,
	input  wire logic        tx_ext_clk_in,
	input  wire logic        rx_rec_clk_in,
	input  wire logic        pll_locked_in,
	input  wire logic        pcs_ready_in,
	// Clock steering and domain resets
	output logic             pll_reset_out,
	output logic             tx_reset_out,
	output logic             rx_reset_out,
	output logic             tx_clk_ext_sel_out,
	output logic             rec_clk_out_en_out,
	output logic             rx_clk_valid_out,
	output logic             core_in_reset_out,
	// AXI4-Lite write address
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read address
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);

	typedef struct packed {
		logic [2:0]              clk_s1;
		logic [2:0]              clk_s2;
		logic [2:0]              clk_prev;
		logic [2:0]              seen;
		logic [2:0]              active;
		logic [4:0]              win_cnt;
		logic                    rst_s1;
		logic                    rst_s2;
		logic                    lock_s1;
		logic                    lock_s2;
		logic                    rdy_s1;
		logic                    rdy_s2;
		clk_rst_pkg::seq_state_t fsm;
		logic [3:0]              hold_cnt;
		logic [2:0]              ctrl;
		logic                    aw_got;
		logic [7:0]              awaddr;
		logic                    w_got;
		logic [31:0]             wdata;
		logic [3:0]              wstrb;
		logic                    bvalid;
		logic [1:0]              bresp;
		logic                    rvalid;
		logic [31:0]             rdata;
		logic [1:0]              rresp;
	} state_t;

	state_t s_q;
	state_t s_d;

	// Word address decode shared by read and write paths
	function automatic logic [1:0] reg_sel(input logic [7:0] addr);
		case (addr)
			clk_rst_pkg::CTRL_OFFSET:   reg_sel = clk_rst_pkg::SEL_CTRL;
			clk_rst_pkg::STATUS_OFFSET: reg_sel = clk_rst_pkg::SEL_STATUS;
			clk_rst_pkg::INFO_OFFSET:   reg_sel = clk_rst_pkg::SEL_INFO;
			default:                    reg_sel = clk_rst_pkg::SEL_NONE;
		endcase
	endfunction

	logic req_reset;
	logic [31:0] status_word;

	// Core reset request: pin or software hold
	assign req_reset = s_q.rst_s2 | s_q.ctrl[clk_rst_pkg::CTRL_SOFT_BIT];

	// Status word built from synchronised observations
	always_comb
	begin
		status_word = 32'h0;
		status_word[clk_rst_pkg::STAT_ACT_LSB +: 3] = s_q.active;
		status_word[clk_rst_pkg::STAT_LOCK_BIT]     = s_q.lock_s2;
		status_word[clk_rst_pkg::STAT_RDY_BIT]      = s_q.rdy_s2;
		status_word[clk_rst_pkg::STAT_FSM_LSB +: 5] = s_q.fsm;
	end

	// Next-state logic for the whole block
	always_comb
	begin
		s_d = s_q;

		// Two-flop synchronisers; first stage feeds only the second
		s_d.clk_s1  = {rx_rec_clk_in, tx_ext_clk_in, ref_clk_in};
		s_d.clk_s2  = s_q.clk_s1;
		s_d.rst_s1  = core_reset_in;
		s_d.rst_s2  = s_q.rst_s1;
		s_d.lock_s1 = pll_locked_in;
		s_d.lock_s2 = s_q.lock_s1;
		s_d.rdy_s1  = pcs_ready_in;
		s_d.rdy_s2  = s_q.rdy_s1;

		// Activity monitor: a clock that toggles in the window counts as running.
		// Fast clocks alias at this rate, so this only tells alive from stopped.
		s_d.clk_prev = s_q.clk_s2;
		s_d.seen     = s_q.seen | (s_q.clk_s2 ^ s_q.clk_prev);
		if (s_q.win_cnt == 5'(clk_rst_pkg::ACT_WINDOW_CYCLES - 1))
		begin
			// Include a toggle seen in the last cycle so it is not lost
			s_d.win_cnt = 5'h0;
			s_d.active  = s_d.seen;
			s_d.seen    = 3'h0;
		end
		else
		begin
			s_d.win_cnt = s_q.win_cnt + 5'h1;
		end

		// Reset release sequencer
		case (s_q.fsm)
			clk_rst_pkg::ST_HOLD:
			begin
				// Stretch every request to the minimum hold time
				if (req_reset)
					s_d.hold_cnt = 4'h0;
				else if (s_q.hold_cnt == 4'(clk_rst_pkg::HOLD_CYCLES - 1))
					s_d.fsm = clk_rst_pkg::ST_WAIT_REF;
				else
					s_d.hold_cnt = s_q.hold_cnt + 4'h1;
			end
			clk_rst_pkg::ST_WAIT_REF:
			begin
				// Reference must be alive before the PLL leaves reset
				if (s_q.active[0])
					s_d.fsm = clk_rst_pkg::ST_PLL;
			end
			clk_rst_pkg::ST_PLL:
			begin
				// Transceiver and coding clocks only trusted once locked
				if (s_q.lock_s2)
					s_d.fsm = clk_rst_pkg::ST_TX;
			end
			clk_rst_pkg::ST_TX:
			begin
				// External source must be running when it is selected
				if (!s_q.ctrl[clk_rst_pkg::CTRL_EXT_TX_BIT] || s_q.active[1])
					s_d.fsm = clk_rst_pkg::ST_RUN;
			end
			clk_rst_pkg::ST_RUN:
			begin
				// Lost lock drops the core back to the hold sequence
				// Restart the count so a lock loss gets the full stretch
				if (!s_q.lock_s2)
				begin
					s_d.fsm      = clk_rst_pkg::ST_HOLD;
					s_d.hold_cnt = 4'h0;
				end
			end
			default:
				s_d.fsm = clk_rst_pkg::ST_HOLD;
		endcase
		if (req_reset)
		begin
			s_d.fsm      = clk_rst_pkg::ST_HOLD;
			s_d.hold_cnt = 4'h0;
		end

		// Write channel: address and data taken in either order
		if (s_axi_awvalid && s_axi_awready)
		begin
			s_d.aw_got = 1'b1;
			s_d.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			s_d.w_got = 1'b1;
			s_d.wdata = s_axi_wdata;
			s_d.wstrb = s_axi_wstrb;
		end
		if (s_q.aw_got && s_q.w_got && !s_q.bvalid)
		begin
			s_d.aw_got = 1'b0;
			s_d.w_got  = 1'b0;
			s_d.bvalid = 1'b1;
			if (reg_sel(s_q.awaddr) == clk_rst_pkg::SEL_CTRL)
			begin
				s_d.bresp = clk_rst_pkg::RESP_OKAY;
				if (s_q.wstrb[0])
					s_d.ctrl = s_q.wdata[2:0];
			end
			else if (reg_sel(s_q.awaddr) == clk_rst_pkg::SEL_NONE)
				s_d.bresp = clk_rst_pkg::RESP_SLVERR;
			else
				s_d.bresp = clk_rst_pkg::RESP_OKAY; // Read-only words ignore data
		end
		if (s_q.bvalid && s_axi_bready)
			s_d.bvalid = 1'b0;

		// Read channel: data captured on address acceptance
		if (s_axi_arvalid && s_axi_arready)
		begin
			s_d.rvalid = 1'b1;
			s_d.rresp  = clk_rst_pkg::RESP_OKAY;
			case (reg_sel(s_axi_araddr))
				clk_rst_pkg::SEL_CTRL:   s_d.rdata = {29'h0, s_q.ctrl};
				clk_rst_pkg::SEL_STATUS: s_d.rdata = status_word;
				clk_rst_pkg::SEL_INFO:   s_d.rdata = 32'(clk_rst_pkg::HOLD_CYCLES);
				default:
				begin
					s_d.rdata = 32'h0;
					s_d.rresp = clk_rst_pkg::RESP_SLVERR;
				end
			endcase
		end
		else if (s_q.rvalid && s_axi_rready)
			s_d.rvalid = 1'b0;

		// Management-side synchronous reset clears only the register port
		if (mgmt_reset_in)
		begin
			s_d.ctrl   = clk_rst_pkg::CTRL_RESET;
			s_d.aw_got = 1'b0;
			s_d.w_got  = 1'b0;
			s_d.bvalid = 1'b0;
			s_d.rvalid = 1'b0;
		end
	end

	// State register; constants only under asynchronous reset
	always_ff @(posedge sys_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			s_q          <= '0;
			s_q.fsm      <= clk_rst_pkg::ST_HOLD;
			s_q.ctrl     <= clk_rst_pkg::CTRL_RESET;
		end
		else
			s_q <= s_d;
	end

	// Bus handshakes: one write and one read in flight
	assign s_axi_awready = !s_q.aw_got && !s_q.bvalid && !mgmt_reset_in;
	assign s_axi_wready  = !s_q.w_got && !s_q.bvalid && !mgmt_reset_in;
	assign s_axi_arready = !s_q.rvalid && !mgmt_reset_in;
	assign s_axi_bvalid  = s_q.bvalid;
	assign s_axi_bresp   = s_q.bresp;
	assign s_axi_rvalid  = s_q.rvalid;
	assign s_axi_rdata   = s_q.rdata;
	assign s_axi_rresp   = s_q.rresp;

	// PLL reset released first, then the other domain resets together in ST_RUN;
	// each domain re-times the release on its own clock before use
	assign pll_reset_out      = s_q.fsm[0] | s_q.fsm[1];
	assign tx_reset_out       = !s_q.fsm[4];
	assign rx_reset_out       = !s_q.fsm[4];
	assign core_in_reset_out  = !s_q.fsm[4];
	assign tx_clk_ext_sel_out = s_q.ctrl[clk_rst_pkg::CTRL_EXT_TX_BIT];
	// Recovered clock forwarded raw; filtering is left to the user
	assign rec_clk_out_en_out = s_q.ctrl[clk_rst_pkg::CTRL_SYNCE_BIT]
		& s_q.active[2];
	// Receive clock trusted only with coding ready and the core running
	assign rx_clk_valid_out   = s_q.rdy_s2 & s_q.fsm[4];

endmodule // clk_rst_ctrl

`default_nettype wire

// [verif/clk_rst_ctrl_properties.sv]
`timescale 1ns/1ps
`default_nettype none

module clk_rst_ctrl_checker
(
	// Clock, resets and pins
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire logic mgmt_reset_in,
	input wire logic core_reset_in,
	input wire logic pll_locked_in,
	input wire logic pcs_ready_in,
	input wire logic pll_reset_out,
	input wire logic tx_reset_out,
	input wire logic core_in_reset_out,
	input wire logic tx_clk_ext_sel_out,
	input wire logic rx_clk_valid_out,
	// Register write channels
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid
);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!rst_n_in);

	// Recent writes or port resets; the select may only move after one
	logic [2:0] evt_q;
	always_ff @(posedge sys_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			evt_q <= 3'h0;
		else
			evt_q <= {evt_q[1:0], (s_axi_wvalid && s_axi_wready) || mgmt_reset_in};
	end

	property p_core_req; core_reset_in |-> ##[1:4] core_in_reset_out; endproperty
	a_core_req: assert property (p_core_req) else $error("core request ignored");
	property p_hold_min; $rose(core_in_reset_out) |-> core_in_reset_out[*8]; endproperty
	a_hold_min: assert property (p_hold_min) else $error("reset too short");
	property p_pll_first;
		$fell(core_in_reset_out) |-> !pll_reset_out && !$past(pll_reset_out, 2);
	endproperty
	a_pll_first: assert property (p_pll_first) else $error("pll not ready");
	property p_lock_loss; $fell(pll_locked_in) && !tx_reset_out |-> ##[1:6] tx_reset_out;
	endproperty
	a_lock_loss: assert property (p_lock_loss) else $error("lock loss kept run");
	property p_rx_valid; $fell(pcs_ready_in) |-> ##[1:4] !rx_clk_valid_out; endproperty
	a_rx_valid: assert property (p_rx_valid) else $error("rx clock still valid");
	property p_ext_sel; $changed(tx_clk_ext_sel_out) |-> |evt_q; endproperty
	a_ext_sel: assert property (p_ext_sel) else $error("select moved alone");
	property p_mgmt; mgmt_reset_in |-> !s_axi_awready ##1 !s_axi_bvalid; endproperty
	a_mgmt: assert property (p_mgmt) else $error("port reset ignored");
	property p_wr_resp;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !mgmt_reset_in
			|=> ##1 s_axi_bvalid;
	endproperty
	a_wr_resp: assert property (p_wr_resp) else $error("late write response");

	// Main scenarios
	c_release: cover property ($fell(tx_reset_out));
	c_lock_loss: cover property ($fell(pll_locked_in) && !tx_reset_out);
	c_port_reset: cover property (mgmt_reset_in);
endmodule // clk_rst_ctrl_checker

`default_nettype wire

// [verif/board_clk_src.sv]
`timescale 1ns/1ps
`default_nettype none

module board_clk_src
(
	// Management clock and source switches
	input wire logic sys_clk_in,
	input wire logic ref_on_in,
	input wire logic ext_on_in,
	input wire logic rec_on_in,
	input wire logic lock_on_in,
	// Clocks and lock seen by the core
	output logic     ref_clk_out,
	output logic     tx_ext_clk_out,
	output logic     rx_rec_clk_out,
	output logic     pll_locked_out
);
	logic [2:0] lock_cnt_q = 3'h0;

	// Clocks stand still while off; scaled slow so the core can sample them
	initial
	begin
		ref_clk_out = 1'b0;
		tx_ext_clk_out = 1'b0;
		rx_rec_clk_out = 1'b0;
	end
	always #20 ref_clk_out = ref_on_in ? ~ref_clk_out : ref_clk_out;
	always @(posedge ref_clk_out) tx_ext_clk_out <= ext_on_in ^ tx_ext_clk_out;
	always #27 rx_rec_clk_out = rec_on_in ? ~rx_rec_clk_out : rx_rec_clk_out;
	// Lane clocks are not observed by the core, so none are modelled

	// Lock follows a running reference after a few cycles, drops at once
	always @(posedge sys_clk_in)
		lock_cnt_q <= (lock_on_in && ref_on_in) ? lock_cnt_q + {2'h0, lock_cnt_q != 3'h7} : 3'h0;
	assign pll_locked_out = (lock_cnt_q == 3'h7);
endmodule // board_clk_src

`default_nettype wire

// [verif/tb_mac_clock_reset_frame.sv]
`timescale 1ns/1ps
`default_nettype none

module tb_mac_clock_reset_frame;
	logic        sys_clk_in = 1'b0, rst_n_in = 1'b0, mgmt_reset_in = 1'b0, core_reset_in = 1'b1;
	logic        ref_on = 1'b0, ext_on = 1'b0, rec_on = 1'b0, lock_on = 1'b0, pcs_ready_in = 1'b0;
	logic        ref_clk_in, tx_ext_clk_in, rx_rec_clk_in, pll_locked_in, pll_reset_out;
	logic        tx_reset_out, rx_reset_out, tx_clk_ext_sel_out, rec_clk_out_en_out;
	logic        rx_clk_valid_out, core_in_reset_out, s_axi_awready, s_axi_wready;
	logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r;
	int          err_count = 0, num_checks = 0;

	// One source serves the management clock of the core and of the board model
	always #5 sys_clk_in = ~sys_clk_in;
	board_clk_src u_src (.sys_clk_in, .ref_on_in(ref_on), .ext_on_in(ext_on), .rec_on_in(rec_on),
		.lock_on_in(lock_on), .ref_clk_out(ref_clk_in), .tx_ext_clk_out(tx_ext_clk_in),
		.rx_rec_clk_out(rx_rec_clk_in), .pll_locked_out(pll_locked_in));
	clk_rst_ctrl u_dut (.sys_clk_in, .rst_n_in, .mgmt_reset_in, .core_reset_in, .ref_clk_in,
		.tx_ext_clk_in, .rx_rec_clk_in, .pll_locked_in, .pcs_ready_in, .pll_reset_out,
		.tx_reset_out, .rx_reset_out, .tx_clk_ext_sel_out, .rec_clk_out_en_out, .rx_clk_valid_out,
		.core_in_reset_out, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

	task automatic chk(input logic ok, input string m);
		num_checks++;
		if (ok !== 1'b1)
		begin
			err_count++;
			$display("BAD %0t %s", $time, m);
		end
	endtask

	// Address and data offered together, each dropped once taken
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
		logic aw;
		logic w;
		aw = 1'b0;
		w = 1'b0;
		@(posedge sys_clk_in);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(aw && w))
		begin
			@(posedge sys_clk_in);
			aw = aw || (s_axi_awready === 1'b1);
			w = w || (s_axi_wready === 1'b1);
			s_axi_awvalid <= !aw;
			s_axi_wvalid <= !w;
		end
		do
			@(posedge sys_clk_in);
		while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	task automatic axi_rd(input logic [7:0] a);
		@(posedge sys_clk_in);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
			@(posedge sys_clk_in);
		while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do
			@(posedge sys_clk_in);
		while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	// Bounded wait for the domains to come out of reset
	task automatic wait_run;
		int n;
		n = 0;
		while (tx_reset_out !== 1'b0 && n < 300)
		begin
			@(posedge sys_clk_in);
			n++;
		end
		repeat (3) @(posedge sys_clk_in);
		chk(rx_reset_out === 1'b0 && pll_reset_out === 1'b0, "no release");
	endtask

	task automatic t_regs;
		axi_rd(clk_rst_pkg::INFO_OFFSET);
		chk(d === 32'(clk_rst_pkg::HOLD_CYCLES) && r === clk_rst_pkg::RESP_OKAY, "info");
		axi_wr(clk_rst_pkg::CTRL_OFFSET, 32'h00000003);
		axi_rd(clk_rst_pkg::CTRL_OFFSET);
		chk(d[2:0] === 3'h3 && tx_clk_ext_sel_out === 1'b1, "ctrl");
		axi_wr(8'h0c, 32'hffffffff);
		chk(r === clk_rst_pkg::RESP_SLVERR, "unmapped write");
		axi_rd(8'h0c);
		chk(r === clk_rst_pkg::RESP_SLVERR && d === 32'h0, "unmapped read");
		$display("t_regs done");
	endtask

	task automatic t_bringup;
		logic [31:0] st_exp;
		ref_on <= 1'b1;
		lock_on <= 1'b1;
		rec_on <= 1'b1;
		pcs_ready_in <= 1'b1;
		core_reset_in <= 1'b0;
		repeat (60) @(posedge sys_clk_in);
		chk(core_in_reset_out === 1'b1, "ran without tx clock");
		ext_on <= 1'b1;
		wait_run;
		chk(rx_clk_valid_out === 1'b1, "rx clock");
		chk(rec_clk_out_en_out === 1'b1, "recovered out");
		// All three clocks alive, locked, ready, core running
		st_exp = (32'(clk_rst_pkg::ST_RUN) << clk_rst_pkg::STAT_FSM_LSB)
			| (32'h1 << clk_rst_pkg::STAT_RDY_BIT) | (32'h1 << clk_rst_pkg::STAT_LOCK_BIT)
			| (32'h7 << clk_rst_pkg::STAT_ACT_LSB);
		axi_rd(clk_rst_pkg::STATUS_OFFSET);
		chk(d === st_exp && r === clk_rst_pkg::RESP_OKAY, "status");
		axi_wr(clk_rst_pkg::STATUS_OFFSET, 32'h00000000);
		chk(r === clk_rst_pkg::RESP_OKAY, "status write");
		$display("t_bringup done");
	endtask

	task automatic t_faults;
		pcs_ready_in <= 1'b0;
		repeat (5) @(posedge sys_clk_in);
		chk(rx_clk_valid_out === 1'b0, "rx valid");
		pcs_ready_in <= 1'b1;
		lock_on <= 1'b0;
		repeat (6) @(posedge sys_clk_in);
		chk(core_in_reset_out === 1'b1 && tx_reset_out === 1'b1, "lock loss");
		lock_on <= 1'b1;
		wait_run;
		core_reset_in <= 1'b1;
		@(posedge sys_clk_in);
		core_reset_in <= 1'b0;
		repeat (8) @(posedge sys_clk_in);
		chk(core_in_reset_out === 1'b1, "core request");
		wait_run;
		rst_n_in <= 1'b0;
		#2;
		chk(tx_reset_out === 1'b1 && tx_clk_ext_sel_out === 1'b0, "async reset");
		repeat (10) @(posedge sys_clk_in);
		rst_n_in <= 1'b1;
		wait_run;
		$display("t_faults done");
	endtask

	task automatic t_mgmt;
		axi_wr(clk_rst_pkg::CTRL_OFFSET, 32'h00000004);
		repeat (4) @(posedge sys_clk_in);
		chk(core_in_reset_out === 1'b1 && tx_reset_out === 1'b1, "soft reset");
		axi_wr(clk_rst_pkg::CTRL_OFFSET, 32'h00000002);
		wait_run;
		repeat (2) @(posedge sys_clk_in);
		chk(rec_clk_out_en_out === 1'b1, "sync option");
		rec_on <= 1'b0;
		repeat (40) @(posedge sys_clk_in);
		chk(rec_clk_out_en_out === 1'b0, "no data");
		rec_on <= 1'b1;
		mgmt_reset_in <= 1'b1;
		@(posedge sys_clk_in);
		mgmt_reset_in <= 1'b0;
		axi_rd(clk_rst_pkg::CTRL_OFFSET);
		chk(d === 32'h0 && tx_reset_out === 1'b0, "port reset");
		$display("t_mgmt done");
	endtask

	task automatic summarize;
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial
	begin
		repeat (10) @(posedge sys_clk_in);
		rst_n_in <= 1'b1;
		t_regs;
		t_bringup;
		t_faults;
		t_mgmt;
		summarize;
	end

	// Hang guard, far beyond the few hundred cycles of the run
	initial
	begin
		#100000;
		err_count++;
		summarize;
	end
endmodule // tb_mac_clock_reset_frame

bind clk_rst_ctrl clk_rst_ctrl_checker u_chk (.sys_clk_in, .rst_n_in, .mgmt_reset_in,
	.core_reset_in, .pll_locked_in, .pcs_ready_in, .pll_reset_out, .tx_reset_out,
	.core_in_reset_out, .tx_clk_ext_sel_out, .rx_clk_valid_out, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid);

`default_nettype wire
